// file: design/icemu_map.svh
// Fixed addresses, hard-coded words and field positions of the emulation unit.
`ifndef ICEMU_MAP_SVH
`define ICEMU_MAP_SVH

`define ICEMU_RESET_PC 32'hfffc_0020
`define ICEMU_RESET_SSP 32'hfffc_fffc
`define ICEMU_L7_VECTOR 32'hfffc_0010
`define ICEMU_ALINE_OPCODE 16'ha000
`define ICEMU_MON_CS_LO 32'hfffc_0000
`define ICEMU_MON_CS_HI 32'hfffd_ffff
`define ICEMU_MON_ACK_HI 32'hfffc_ffff
`define ICEMU_VEC_SSP_HI 32'h0000_0000
`define ICEMU_VEC_SSP_LO 32'h0000_0002
`define ICEMU_VEC_PC_HI 32'h0000_0004
`define ICEMU_VEC_PC_LO 32'h0000_0006
`define ICEMU_ALINE_VEC_HI 32'h0000_0028
`define ICEMU_ALINE_VEC_LO 32'h0000_002a
`define ICEMU_FC_DATA 2'h1
`define ICEMU_FC_PROG 2'h2
`define ICEMU_STAT_PROG 0
`define ICEMU_STAT_BUS 1
`define ICEMU_STAT_PIN 2
`define ICEMU_STAT_RESET 3'h0

`endif

// file: design/icemu_pkg.sv
// Types shared by the in-circuit emulation unit.
`default_nettype none
package icemu_pkg;

    // One core bus cycle as seen by the unit.
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] fc;
        logic read;
        logic as_n;
    } icemu_bus_t;

    // Breakpoint compare setup and control bits.
    typedef struct packed {
        logic [31:0] addr_compare;
        logic [31:0] addr_mask;
        logic rw_compare;
        logic pd_compare;
        logic rw_mask;
        logic pd_mask;
        logic single_break_select;
        logic program_break_select;
        logic compare_enable_bit;
        logic bus_break_irq_enable;
        logic hardmap_disable;
    } icemu_ctrl_t;

    typedef enum logic [2:0] {
        ICEMU_ALINE_IDLE = 3'b001,
        ICEMU_ALINE_ARMED = 3'b010,
        ICEMU_ALINE_HI_SEEN = 3'b100
    } icemu_aline_t;

endpackage : icemu_pkg
`default_nettype wire

// file: design/icemu_unit.sv
// In-circuit emulation unit: mode entry, hardmap, monitor select, breakpoints.
`timescale 1ns/100ps
`default_nettype none
`include "icemu_map.svh"

// What this block does
// - Capture emulation pin at reset release; low level enters emulation mode.
// - After reset each falling edge of the emulation pin raises level 7.
// - In emulation mode boot select stays off for reset fetches, up to the first edge of the low PC word cycle; unit supplies data.
// - Reset fetch returns PC 0xFFFC0020 and stack pointer 0xFFFCFFFC.
// - Monitor select covers 0xFFFC0000 to 0xFFFDFFFF as an 8-bit port.
// - Space to 0xFFFCFFFF gets internal acknowledge; data on upper lanes D[15:8].
// - Pin high at reset keeps the unit disabled; device boots normally.
// - One full-width address comparator and one bus control comparator.
// - Single mode drives breakpoint pin, qualified by strobe, for whole cycle.
// - Multiple mode reads breakpoint pin and ANDs it with internal compare.
// - Matched instruction fetch gets 0xA000 in place of memory data.
// - After insertion, the A-line exception raises level 7 for a program hit.
// - Vector fetch is word reads 0x28 then 0x2A, counted only when armed.
// - Plain reads of the A-line vector words raise no level 7.
// - Breakpoint pin asserts during the A-line vector fetch at a breakpoint.
// - Program/data output is low for data cycles, high for program cycles.
// - Level 7 merges program hits, bus hits and emulation pin edges.
// - With hardmap enabled the level 7 vector is 0xFFFC0010.
// - Each level 7 source has a status bit cleared by writing one.
// - With emulation disabled only the emulation pin causes level 7.
// - Single-break set makes pin an output; clear makes it an input.
// - A set mask bit makes that address bit compare true.
// - Comparison stays inactive until compare enable is set.
module icemu_unit (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire icemu_pkg::icemu_bus_t bus_i,
    input wire icemu_pkg::icemu_ctrl_t ctrl_i,
    input wire logic [15:0] mem_data_i,
    input wire logic boot_chip_select_req_i,
    input wire logic emu_interrupt_pin_n_i,
    input wire logic breakpoint_pin_n_i,
    input wire logic [2:0] status_clear_i,
    output logic breakpoint_pin_n_o,
    output logic breakpoint_pin_oe_o,
    output logic boot_chip_select_o,
    output logic monitor_chip_select_n_o,
    output logic monitor_ack_o,
    output logic monitor_port_8bit_o,
    output logic data_override_o,
    output logic [15:0] data_o,
    output logic prog_data_o,
    output logic emulation_mode_o,
    output logic [2:0] status_o,
    output logic level7_req_o,
    output logic level7_vector_valid_o,
    output logic [31:0] level7_vector_o
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic irq_meta_reg;
    logic irq_sync_reg;
    logic irq_prev_reg;
    logic brk_meta_reg;
    logic brk_sync_reg;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_meta_reg <= 1'b1;
            irq_sync_reg <= 1'b1;
            irq_prev_reg <= 1'b1;
            brk_meta_reg <= 1'b1;
            brk_sync_reg <= 1'b1;
        end else begin
            irq_meta_reg <= emu_interrupt_pin_n_i;
            irq_sync_reg <= irq_meta_reg;
            irq_prev_reg <= irq_sync_reg;
            brk_meta_reg <= breakpoint_pin_n_i;
            brk_sync_reg <= brk_meta_reg;
        end
    end

    // Flops idle at one in reset, so a pin held low shows one clean fall afterwards.
    logic pin_fall;
    assign pin_fall = irq_prev_reg & ~irq_sync_reg;

    // ----------------------------------------------------------------
    // Mode capture at reset release
    // ----------------------------------------------------------------
    // The pin runs through its own two flops; the last reset edge freezes the mode.
    logic emu_mode_reg;
    logic cap_meta_reg;
    logic cap_sync_reg;

    always_ff @(posedge mclk_i) begin
        cap_meta_reg <= emu_interrupt_pin_n_i;
        cap_sync_reg <= cap_meta_reg;
        if (rst_i) begin
            emu_mode_reg <= ~cap_sync_reg;
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle decode
    // ----------------------------------------------------------------
    logic as_prev_reg;
    logic cyc_start;
    logic cyc_on;
    logic prog_cycle;
    logic data_cycle;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            as_prev_reg <= 1'b1;
        end else begin
            as_prev_reg <= bus_i.as_n;
        end
    end

    assign cyc_on = ~bus_i.as_n;
    assign cyc_start = cyc_on & as_prev_reg;
    assign prog_cycle = bus_i.fc[1:0] == `ICEMU_FC_PROG;
    assign data_cycle = bus_i.fc[1:0] == `ICEMU_FC_DATA;

    // ----------------------------------------------------------------
    // Breakpoint comparators
    // ----------------------------------------------------------------
    logic addr_hit;
    logic ctrl_hit;
    logic int_match;
    logic ext_low;
    logic match;

    assign addr_hit = &((bus_i.addr ~^ ctrl_i.addr_compare) | ctrl_i.addr_mask);
    assign ctrl_hit = (ctrl_i.rw_mask | (bus_i.read == ctrl_i.rw_compare)) &
                      (ctrl_i.pd_mask | (prog_cycle == ctrl_i.pd_compare));
    // Program breaks ignore the control comparator and fire on fetches only.
    assign int_match = emu_mode_reg & ctrl_i.compare_enable_bit & cyc_on & addr_hit &
                       (ctrl_i.program_break_select ? prog_cycle : ctrl_hit);
    assign ext_low = ~brk_sync_reg;
    assign match = int_match & (ctrl_i.single_break_select | ext_low);

    // ----------------------------------------------------------------
    // A-line exception tracking
    // ----------------------------------------------------------------
    icemu_pkg::icemu_aline_t aline_reg;
    icemu_pkg::icemu_aline_t aline_next;
    logic insert;
    logic vec_hi;
    logic vec_lo;
    logic aline_fetch;
    logic prog_hit;

    assign insert = match & ctrl_i.program_break_select & prog_cycle & bus_i.read;
    assign vec_hi = cyc_start & bus_i.read & (bus_i.addr == `ICEMU_ALINE_VEC_HI);
    assign vec_lo = cyc_start & bus_i.read & (bus_i.addr == `ICEMU_ALINE_VEC_LO);
    assign prog_hit = (aline_reg == icemu_pkg::ICEMU_ALINE_HI_SEEN) & vec_lo;
    assign aline_fetch = cyc_on & (aline_reg == icemu_pkg::ICEMU_ALINE_HI_SEEN);

    always_comb begin
        aline_next = aline_reg;
        case (aline_reg)
            icemu_pkg::ICEMU_ALINE_IDLE: begin
                if (insert) begin
                    aline_next = icemu_pkg::ICEMU_ALINE_ARMED;
                end
            end
            icemu_pkg::ICEMU_ALINE_ARMED: begin
                if (vec_hi) begin
                    aline_next = icemu_pkg::ICEMU_ALINE_HI_SEEN;
                end
            end
            icemu_pkg::ICEMU_ALINE_HI_SEEN: begin
                // The low word, or any other cycle that breaks the pair, ends the fetch.
                if (cyc_start) begin
                    aline_next = icemu_pkg::ICEMU_ALINE_IDLE;
                end
            end
            default: begin
                aline_next = icemu_pkg::ICEMU_ALINE_IDLE;
            end
        endcase
        if (!emu_mode_reg || !ctrl_i.compare_enable_bit) begin
            aline_next = icemu_pkg::ICEMU_ALINE_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aline_reg <= icemu_pkg::ICEMU_ALINE_IDLE;
        end else begin
            aline_reg <= aline_next;
        end
    end

    // ----------------------------------------------------------------
    // Breakpoint pin
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            breakpoint_pin_oe_o <= 1'b0;
            breakpoint_pin_n_o <= 1'b1;
        end else begin
            breakpoint_pin_oe_o <= emu_mode_reg & ctrl_i.single_break_select;
            breakpoint_pin_n_o <= ~(int_match | aline_fetch);
        end
    end

    // ----------------------------------------------------------------
    // Hardmap, reset vector and monitor select
    // ----------------------------------------------------------------
    // The reset window lasts from reset until the first clock edge of a cycle at the low PC word.
    logic reset_fetch_reg;
    logic hardmap_on;
    logic hm_hit;
    logic [15:0] hm_word;
    logic in_mon;
    logic in_ack;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reset_fetch_reg <= 1'b1;
        end else if (cyc_start && bus_i.addr == `ICEMU_VEC_PC_LO) begin
            reset_fetch_reg <= 1'b0;
        end
    end

    assign hardmap_on = emu_mode_reg & ~ctrl_i.hardmap_disable;

    always_comb begin
        hm_hit = bus_i.read & cyc_on;
        hm_word = 16'h0000;
        case (bus_i.addr)
            `ICEMU_VEC_SSP_HI: hm_word = 16'(`ICEMU_RESET_SSP >> 16);
            `ICEMU_VEC_SSP_LO: hm_word = 16'(`ICEMU_RESET_SSP & 32'h0000_ffff);
            `ICEMU_VEC_PC_HI: hm_word = 16'(`ICEMU_RESET_PC >> 16);
            `ICEMU_VEC_PC_LO: hm_word = 16'(`ICEMU_RESET_PC & 32'h0000_ffff);
            `ICEMU_ALINE_VEC_HI: hm_word = 16'(`ICEMU_L7_VECTOR >> 16);
            `ICEMU_ALINE_VEC_LO: hm_word = 16'(`ICEMU_L7_VECTOR & 32'h0000_ffff);
            default: hm_hit = 1'b0;
        endcase
        // Vector words come from the hardmap while it is enabled, and in emulation mode during the reset window.
        hm_hit = hm_hit & (hardmap_on | (emu_mode_reg & reset_fetch_reg));
    end

    assign in_mon = (bus_i.addr >= `ICEMU_MON_CS_LO) & (bus_i.addr <= `ICEMU_MON_CS_HI);
    assign in_ack = (bus_i.addr >= `ICEMU_MON_CS_LO) & (bus_i.addr <= `ICEMU_MON_ACK_HI);

    // Reset fetches bypass the boot device in emulation mode; for the low PC word only until the first clock edge of its cycle.
    assign boot_chip_select_o = boot_chip_select_req_i &
                                ~(emu_mode_reg & reset_fetch_reg & hm_hit);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            monitor_chip_select_n_o <= 1'b1;
            monitor_ack_o <= 1'b0;
            monitor_port_8bit_o <= 1'b0;
        end else begin
            monitor_chip_select_n_o <= ~(emu_mode_reg & cyc_on & in_mon);
            monitor_ack_o <= emu_mode_reg & cyc_on & in_ack;
            monitor_port_8bit_o <= emu_mode_reg & cyc_on & in_mon;
        end
    end

    // ----------------------------------------------------------------
    // Data override and cycle type
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_override_o <= 1'b0;
            data_o <= 16'h0000;
            prog_data_o <= 1'b0;
        end else begin
            data_override_o <= insert | hm_hit;
            if (insert) begin
                data_o <= `ICEMU_ALINE_OPCODE;
            end else if (hm_hit) begin
                data_o <= hm_word;
            end else begin
                data_o <= mem_data_i;
            end
            if (prog_cycle) begin
                prog_data_o <= 1'b1;
            end else if (data_cycle) begin
                prog_data_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt gate and status
    // ----------------------------------------------------------------
    logic [2:0] stat_reg;
    logic [2:0] stat_set;
    logic bus_hit;
    logic bus_seen_reg;

    // One hit per strobe; in multiple mode the synced pin only lands some edges in.
    assign bus_hit = match & ~ctrl_i.program_break_select & ~bus_seen_reg;
    always_ff @(posedge mclk_i) begin
        bus_seen_reg <= ~rst_i & ~bus_i.as_n & (bus_seen_reg | bus_hit);
    end
    assign stat_set[`ICEMU_STAT_PROG] = prog_hit & ctrl_i.program_break_select;
    assign stat_set[`ICEMU_STAT_BUS] = bus_hit & ctrl_i.bus_break_irq_enable;
    assign stat_set[`ICEMU_STAT_PIN] = pin_fall;

    // A source event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stat_reg <= `ICEMU_STAT_RESET;
        end else begin
            stat_reg <= (stat_reg & ~status_clear_i) | stat_set;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            level7_req_o <= 1'b0;
            level7_vector_valid_o <= 1'b0;
            level7_vector_o <= 32'h0000_0000;
        end else begin
            level7_req_o <= stat_reg[`ICEMU_STAT_PIN] |
                            (emu_mode_reg & (stat_reg[`ICEMU_STAT_PROG] |
                                             stat_reg[`ICEMU_STAT_BUS]));
            level7_vector_valid_o <= hardmap_on;
            level7_vector_o <= `ICEMU_L7_VECTOR;
        end
    end

    assign status_o = stat_reg;
    assign emulation_mode_o = emu_mode_reg;

endmodule : icemu_unit
`default_nettype wire

// file: test/icemu_emulator.sv
// Behavioural emulator pod: mode request, interrupt pin and low-address comparator.
`timescale 1ns/100ps
`default_nettype none
module icemu_emulator (
    input wire logic rst_i,
    input wire logic want_emu_i,
    input wire logic fire_i,
    input wire icemu_pkg::icemu_bus_t bus_i,
    input wire logic lo_en_i,
    input wire logic [7:0] lo_tgt_i,
    output logic irq_n_o,
    output logic brk_drive_o,
    output logic brk_n_o
);
    // --------
    // Pod behaviour
    // --------
    // The pin is held low for the whole reset, so the last capture edge sees it low.
    assign irq_n_o = !((want_emu_i && rst_i) || fire_i);
    // Only the low address byte is compared here; the unit covers the upper bits.
    assign brk_drive_o = lo_en_i && !bus_i.as_n && bus_i.addr[7:0] == lo_tgt_i;
    assign brk_n_o = !brk_drive_o;
endmodule : icemu_emulator
`default_nettype wire

// file: test/icemu_chk.sv
// Port checker of the in-circuit emulation unit.
`timescale 1ns/100ps
`default_nettype none
`include "icemu_map.svh"
module icemu_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire icemu_pkg::icemu_bus_t bus_i,
    input wire icemu_pkg::icemu_ctrl_t ctrl_i,
    input wire logic [15:0] mem_data_i,
    input wire logic boot_chip_select_req_i,
    input wire logic emu_interrupt_pin_n_i,
    input wire logic breakpoint_pin_n_i,
    input wire logic [2:0] status_clear_i,
    input wire logic breakpoint_pin_n_o,
    input wire logic breakpoint_pin_oe_o,
    input wire logic boot_chip_select_o,
    input wire logic monitor_chip_select_n_o,
    input wire logic monitor_ack_o,
    input wire logic monitor_port_8bit_o,
    input wire logic data_override_o,
    input wire logic [15:0] data_o,
    input wire logic prog_data_o,
    input wire logic emulation_mode_o,
    input wire logic [2:0] status_o,
    input wire logic level7_req_o,
    input wire logic level7_vector_valid_o,
    input wire logic [31:0] level7_vector_o
);
    // --------
    // Properties
    // --------
    logic act;
    logic hit;
    logic in_mon;
    logic in_ack;
    assign act = emulation_mode_o && !bus_i.as_n;
    assign hit = act && ctrl_i.compare_enable_bit && ctrl_i.single_break_select &&
        ((bus_i.addr ^ ctrl_i.addr_compare) & ~ctrl_i.addr_mask) == 32'h0;
    assign in_mon = act && bus_i.addr >= `ICEMU_MON_CS_LO && bus_i.addr <= `ICEMU_MON_CS_HI;
    assign in_ack = in_mon && bus_i.addr <= `ICEMU_MON_ACK_HI;
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence fetch_s;
        hit && ctrl_i.program_break_select && bus_i.read && bus_i.fc[1:0] == `ICEMU_FC_PROG;
    endsequence
    sequence bus_s;
        hit && !ctrl_i.program_break_select && ctrl_i.rw_mask && ctrl_i.pd_mask;
    endsequence
    // The pin must have been high for a while, so the rise after reset is no edge.
    sequence fall_s;
        $fell(emu_interrupt_pin_n_i) && $past(emu_interrupt_pin_n_i, 3);
    endsequence
    AST_MON_SEL: assert property (in_mon |=> !monitor_chip_select_n_o)
        else $error("monitor select missing");
    AST_MON_ACK: assert property (in_ack |=> monitor_ack_o && monitor_port_8bit_o)
        else $error("monitor acknowledge missing");
    AST_NO_MON: assert property (!emulation_mode_o |=> monitor_chip_select_n_o)
        else $error("monitor select outside emulation");
    AST_PD: assert property (!bus_i.as_n && bus_i.fc[1:0] == `ICEMU_FC_PROG |=> prog_data_o)
        else $error("program indicator low");
    AST_INSERT: assert property (fetch_s |=>
        data_override_o && data_o == `ICEMU_ALINE_OPCODE)
        else $error("opcode not inserted");
    AST_BRK_OUT: assert property (bus_s |=> !breakpoint_pin_n_o && breakpoint_pin_oe_o)
        else $error("breakpoint pin not driven");
    AST_PIN_IRQ: assert property (fall_s |-> ##[1:5] status_o[2])
        else $error("pin edge not recorded");
    AST_STAT_CLR: assert property (status_o[0] && status_clear_i[0] && bus_i.as_n |=>
        !status_o[0])
        else $error("status not cleared");
    AST_L7_NOEMU: assert property (!emulation_mode_o && !status_o[2] |=> !level7_req_o)
        else $error("level 7 without pin source");
    AST_VEC: assert property (act && !ctrl_i.hardmap_disable |=>
        level7_vector_valid_o && level7_vector_o == `ICEMU_L7_VECTOR)
        else $error("level 7 vector wrong");
endmodule : icemu_chk
`default_nettype wire

// file: test/icemu_unit_tb.sv
// Self-checking bench of the emulation unit with an emulator pod model.
`timescale 1ns/100ps
`default_nettype none
`include "icemu_map.svh"
module icemu_unit_tb;
    // --------
    // Stimulus, wiring and checks
    // --------
    localparam logic [31:0] RST_SSP = `ICEMU_RESET_SSP;
    localparam logic [31:0] RST_PC = `ICEMU_RESET_PC;
    localparam logic [31:0] L7V = `ICEMU_L7_VECTOR;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    icemu_pkg::icemu_bus_t bus_i = {32'h0, 3'h5, 1'b1, 1'b1};
    icemu_pkg::icemu_ctrl_t ctrl_i = '0;
    logic [2:0] status_clear_i = 3'h0;
    logic want_emu = 1'b1, fire = 1'b0, lo_en = 1'b0, boot_req = 1'b1;
    logic irq_n, ext_drv, ext_n, brk_n, brk_oe, brk_w, boot_cs, cs_n, ack, m8, ovr, pd, emu;
    logic l7, vval, boot_s, cs_s, ack_s, m8_s, ovr_s, brk_s;
    logic [15:0] dat, dat_s;
    logic [2:0] stat;
    logic [31:0] vec;
    logic [3:0] obs;
    int n_mismatch = 0, checks_done = 0;
    // The pin has a pull-up, so a released line reads high.
    assign brk_w = brk_oe ? brk_n : (ext_drv ? ext_n : 1'b1);
    assign obs = {l7, stat};
    always #5 mclk_i = ~mclk_i;
    icemu_emulator i_icemu_emulator (.rst_i(rst_i), .want_emu_i(want_emu), .fire_i(fire),
        .bus_i(bus_i), .lo_en_i(lo_en), .lo_tgt_i(8'h34), .irq_n_o(irq_n),
        .brk_drive_o(ext_drv), .brk_n_o(ext_n));
    icemu_unit i_icemu_unit (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .ctrl_i(ctrl_i),
        .mem_data_i(16'h1234), .boot_chip_select_req_i(boot_req), .emu_interrupt_pin_n_i(irq_n),
        .breakpoint_pin_n_i(brk_w), .status_clear_i(status_clear_i),
        .breakpoint_pin_n_o(brk_n), .breakpoint_pin_oe_o(brk_oe), .boot_chip_select_o(boot_cs),
        .monitor_chip_select_n_o(cs_n), .monitor_ack_o(ack), .monitor_port_8bit_o(m8),
        .data_override_o(ovr), .data_o(dat), .prog_data_o(pd), .emulation_mode_o(emu),
        .status_o(stat), .level7_req_o(l7), .level7_vector_valid_o(vval),
        .level7_vector_o(vec));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic m);
        want_emu = m;
        rst_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (6) @(negedge mclk_i);
    endtask : do_reset
    // One read cycle of len edges; outputs are captured before the strobe is released.
    task automatic cyc(input logic [31:0] a, input logic [2:0] fc, input int len);
        bus_i.addr = a;
        bus_i.fc = fc;
        bus_i.as_n = 1'b0;
        #1 boot_s = boot_cs;
        repeat (len) @(negedge mclk_i);
        {cs_s, ack_s, m8_s, ovr_s, brk_s, dat_s} = {cs_n, ack, m8, ovr, brk_w, dat};
        bus_i.as_n = 1'b1;
        @(negedge mclk_i);
    endtask : cyc
    task automatic setc(input logic [31:0] c, input logic [31:0] m, input logic [4:0] b);
        ctrl_i = {c, m, 4'h3, b};
    endtask : setc
    task automatic poll(input int idx, input logic v);
        int k;
        for (k = 0; k < 8 && obs[idx] !== v; k++) begin
            @(negedge mclk_i);
        end
        chk(obs[idx], v);
    endtask : poll
    task automatic clr(input int idx);
        status_clear_i[idx] = 1'b1;
        @(negedge mclk_i);
        status_clear_i = 3'h0;
    endtask : clr
    task automatic t_reset;
        logic [63:0] rv;
        int i;
        rv = {RST_SSP, RST_PC};
        chk(emu, 1'b1);
        for (i = 0; i < 4; i++) begin
            cyc(32'(2 * i), 3'h5, 1);
            chk(boot_s, 1'b0);
            chk(ovr_s, 1'b1);
            chk(dat_s, rv[63 - 16 * i -: 16]);
        end
        cyc(32'h0, 3'h5, 1);
        chk(boot_s, 1'b1);
    endtask : t_reset
    task automatic t_mon;
        logic [31:0] a [6] = '{32'hfffc0000, 32'hfffcffff, 32'hfffd0000, 32'hfffdffff,
            32'hfffbffff, 32'hfffe0000};
        logic [1:0] e [6] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0};
        foreach (a[i]) begin
            cyc(a[i], 3'h5, 1);
            chk(cs_s, !e[i][0]);
            chk(m8_s, e[i][0]);
            chk(ack_s, e[i][1]);
            chk(dat_s, 16'h1234);
        end
    endtask : t_mon
    task automatic t_pd;
        logic [2:0] f [4] = '{3'h5, 3'h6, 3'h1, 3'h2};
        foreach (f[i]) begin
            cyc(32'h300, f[i], 1);
            chk(pd, f[i][1]);
        end
    endtask : t_pd
    task automatic t_prog;
        setc(32'h1000, 32'hf, 5'h18);
        cyc(32'h100c, 3'h6, 1);
        chk(ovr_s, 1'b0);
        setc(32'h1000, 32'hf, 5'h1c);
        cyc(32'h1010, 3'h6, 1);
        chk(ovr_s, 1'b0);
        cyc(32'h28, 3'h5, 1);
        cyc(32'h2a, 3'h5, 1);
        repeat (4) @(negedge mclk_i);
        chk(stat[0], 1'b0);
        cyc(32'h100c, 3'h6, 1);
        chk(dat_s, 16'ha000);
        chk(brk_s, 1'b0);
        cyc(32'h28, 3'h5, 1);
        cyc(32'h2a, 3'h5, 1);
        chk(brk_s, 1'b0);
        chk(dat_s, L7V[15:0]);
        poll(0, 1'b1);
        poll(3, 1'b1);
        chk(vec, L7V);
        chk(vval, 1'b1);
        clr(0);
        poll(0, 1'b0);
        poll(3, 1'b0);
    endtask : t_prog
    task automatic t_bus;
        setc(32'h2000, 32'hff, 5'h16);
        cyc(32'h2034, 3'h5, 1);
        chk(brk_s, 1'b0);
        poll(1, 1'b1);
        clr(1);
        poll(1, 1'b0);
        setc(32'h2000, 32'hff, 5'h06);
        lo_en = 1'b1;
        // Let the echo of the unit's own last drive leave the pin synchroniser.
        repeat (2) @(negedge mclk_i);
        cyc(32'h2035, 3'h5, 4);
        chk(brk_oe, 1'b0);
        repeat (4) @(negedge mclk_i);
        chk(stat[1], 1'b0);
        cyc(32'h2034, 3'h5, 4);
        poll(1, 1'b1);
        clr(1);
        lo_en = 1'b0;
    endtask : t_bus
    task automatic t_pin;
        fire = 1'b1;
        poll(2, 1'b1);
        poll(3, 1'b1);
        repeat (4) @(negedge mclk_i);
        chk(stat[2], 1'b1);
        fire = 1'b0;
        clr(2);
        poll(2, 1'b0);
    endtask : t_pin
    task automatic t_normal;
        setc(32'h1000, 32'hf, 5'h1c);
        do_reset(1'b0);
        chk(emu, 1'b0);
        cyc(32'h4, 3'h5, 1);
        chk(ovr_s, 1'b0);
        chk(boot_s, 1'b1);
        cyc(32'hfffc0000, 3'h5, 1);
        chk(cs_s, 1'b1);
        cyc(32'h1004, 3'h6, 1);
        chk(ovr_s, 1'b0);
        chk(vval, 1'b0);
        t_pin();
    endtask : t_normal
    initial begin
        do_reset(1'b1);
        t_reset();
        t_mon();
        t_pd();
        t_prog();
        t_bus();
        t_pin();
        t_normal();
        wrap_up();
    end
    // The tests need well under a thousand cycles; twenty thousand leaves wide margin.
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
endmodule : icemu_unit_tb
bind icemu_unit icemu_chk i_icemu_chk (.*);
`default_nettype wire
